// file: design/gsl_defs.svh
// Offsets, field positions, reset values and timing counts of the gripper
// status and fault block.
// Assumes a 100 MHz system clock and a plain strobe register port.
`ifndef GSL_DEFS_SVH
`define GSL_DEFS_SVH
`define GSL_ADDR_CTRL     8'h00
`define GSL_ADDR_STATUS   8'h04
`define GSL_ADDR_IRQ_STAT 8'h08
`define GSL_ADDR_IRQ_MASK 8'h0C
`define GSL_CTRL_ACK      0
`define GSL_CTRL_IDLE     1
`define GSL_CTRL_RESET    2'h0
`define GSL_MASK_RESET    4'h0
`define GSL_EV_ERR        0
`define GSL_EV_WARN       1
`define GSL_EV_SEL        2
`define GSL_EV_ACK        3
`define GSL_CODE_NONE     4'h0
`define GSL_CODE_OVERTEMP 4'h1
`define GSL_CODE_FAULT    4'h2
`define GSL_CLK_KHZ       100000
`define GSL_SLOW_MS       1200
`define GSL_FAST_MS       600
`define GSL_COM_MS        50
`define GSL_HOLD_MS       100
`define GSL_SLOW_CYC      (`GSL_SLOW_MS * `GSL_CLK_KHZ)
`define GSL_FAST_CYC      (`GSL_FAST_MS * `GSL_CLK_KHZ)
`define GSL_COM_CYC       (`GSL_COM_MS * `GSL_CLK_KHZ)
`define GSL_HOLD_CYC      (`GSL_HOLD_MS * `GSL_CLK_KHZ)
`endif

// file: design/gsl_pkg.sv
// Types shared by the gripper status and fault block.
// Assumes nothing beyond a SystemVerilog compiler.
package gsl_pkg;
   // Operating state, Gray coded along off, ready, warning, error.
   typedef enum logic [1:0] {
      GSL_OFF   = 2'b00,
      GSL_READY = 2'b01,
      GSL_WARN  = 2'b11,
      GSL_ERR   = 2'b10
   } gsl_state_type;
   // Register port request.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } gsl_bus_type;
   // Indicator outputs.
   typedef struct packed {
      logic ready;
      logic error;
      logic power;
      logic com;
      logic stat_grn;
      logic stat_red;
   } gsl_led_type;
endpackage

// file: design/gsl_blink.sv
// Square wave generator with equal on and off halves.
// Assumes run is a level from the same clock domain.
`timescale 1ns/10ps
`include "gsl_defs.svh"
module gsl_blink
   import gsl_pkg::*;
#(
   parameter logic [26:0] TOGGLE_CYC = 27'(`GSL_FAST_CYC)
) (
   // Clock, reset, enable.
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ce,
   // Control and phase.
   input  wire logic run,
   output logic      phase_r
);
   logic [26:0] cnt_r;
   // Count one half period, then invert the phase; idle holds the on phase.
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r   <= 27'h000_0000;
         phase_r <= 1'b1;
      end else if (ce) begin
         if (!run) begin
            cnt_r   <= 27'h000_0000;
            phase_r <= 1'b1;
         end else if (cnt_r == TOGGLE_CYC - 27'h000_0001) begin
            cnt_r   <= 27'h000_0000;
            phase_r <= ~phase_r;
         end else begin
            cnt_r <= cnt_r + 27'h000_0001;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_half_stable: assert property ((ce && run && cnt_r != TOGGLE_CYC - 27'h000_0001)
      |=> $stable(phase_r)) else $error("blink phase moved mid half");
   a_half_toggle: assert property ((ce && run && cnt_r == TOGGLE_CYC - 27'h000_0001)
      |=> phase_r != $past(phase_r)) else $error("blink phase missed toggle");
endmodule

// file: design/gsl_evreg.sv
// Sticky event bits with write-one-to-clear, a mask and a level interrupt.
// Assumes event pulses and write strobes from the same clock domain.
`timescale 1ns/10ps
`include "gsl_defs.svh"
module gsl_evreg
   import gsl_pkg::*;
(
   // Clock, reset, enable.
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       ce,
   // Events and software access.
   input  wire logic [3:0] ev,
   input  wire logic       wr_stat,
   input  wire logic       wr_mask,
   input  wire logic [3:0] wdata,
   // State and interrupt.
   output logic [3:0]      stat_r,
   output logic [3:0]      mask_r,
   output logic            irq_r
);
   // One sticky bit per event; a new event beats a clear in the same cycle.
   for (genvar i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (reset) begin
            stat_r[i] <= 1'b0;
         end else if (ce) begin
            if (ev[i]) begin
               stat_r[i] <= 1'b1;
            end else if (wr_stat && wdata[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
      end
   end
   // Mask register.
   always_ff @(posedge clk) begin
      if (reset) begin
         mask_r <= `GSL_MASK_RESET;
      end else if (ce && wr_mask) begin
         mask_r <= wdata;
      end
   end
   // Interrupt level from unmasked sticky bits.
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else if (ce) begin
         irq_r <= |(stat_r & mask_r);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_set_wins: assert property ((ce && |ev) |=> ((stat_r & $past(ev)) == $past(ev)))
      else $error("event lost against clear");
endmodule

// file: design/gsl_core.sv
// Status indication and over-temperature fault handling of a gripper.
// Assumes all inputs synchronous to clk and a plain strobe register port.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "gsl_defs.svh"
module gsl_core
   import gsl_pkg::*;
#(
   parameter logic [26:0] SLOW_TOGGLE_CYC = 27'(`GSL_SLOW_CYC),
   parameter logic [26:0] FAST_TOGGLE_CYC = 27'(`GSL_FAST_CYC),
   parameter logic [26:0] COM_TOGGLE_CYC  = 27'(`GSL_COM_CYC),
   parameter logic [26:0] COM_HOLD_CYC    = 27'(`GSL_HOLD_CYC)
) (
   // Clock, reset, enable.
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // Supply and sensing.
   input  wire logic        supply_ok,
   input  wire logic        logic_v_ok,
   input  wire logic        act_v_ok,
   input  wire logic        electronics_ok,
   input  wire logic        ot_warn,
   input  wire logic        ot_err,
   input  wire logic        sel_between,
   input  wire logic        ext_fault,
   input  wire logic        link_activity,
   // Controller commands.
   input  wire logic        cmd_open,
   input  wire logic        cmd_close,
   // Motor side.
   output logic             drv_open_r,
   output logic             drv_close_r,
   output logic             cur_limit_r,
   // Indicators and fault report.
   output gsl_led_type      led_r,
   output logic             err_msg_valid_r,
   output logic [3:0]       err_code_r,
   // Register port.
   input  wire gsl_bus_type bus,
   output logic [31:0]      rd_data_r,
   // Interrupt.
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   gsl_state_type state_r;
   gsl_state_type state_nxt;
   logic          err_r;
   logic          err_nxt;
   logic          warn_r;
   logic          sel_r;
   logic [1:0]    ctrl_r;
   logic          sw_ack_r;
   logic [26:0]   hold_r;
   logic          com_active;
   logic          ack_req;
   logic          ack_ok;
   logic          slow_ph;
   logic          fast_ph;
   logic          com_ph;
   logic          any_fault;
   logic [3:0]    ev;
   logic [3:0]    irq_stat;
   logic [3:0]    irq_mask;
   logic          wr_ctrl;
   logic          wr_stat;
   logic          wr_mask;

   ////////////////////////////////////////////////////////////////////////
   // Register port decode.
   always_comb begin
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (bus.wr && bus.addr == `GSL_ADDR_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (bus.wr && bus.addr == `GSL_ADDR_IRQ_STAT) begin
         wr_stat = 1'b1;
      end else if (bus.wr && bus.addr == `GSL_ADDR_IRQ_MASK) begin
         wr_mask = 1'b1;
      end
   end

   // Control register: stored idle bit, self-clearing acknowledge pulse.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r   <= `GSL_CTRL_RESET;
         sw_ack_r <= 1'b0;
      end else if (ce) begin
         sw_ack_r <= wr_ctrl && bus.wdata[`GSL_CTRL_ACK];
         if (wr_ctrl) begin
            ctrl_r <= bus.wdata[1:0] & 2'h2;
         end
      end
   end

   // Read data valid only in the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_r <= 32'h0000_0000;
      end else if (ce) begin
         rd_data_r <= 32'h0000_0000;
         if (bus.rd) begin
            if (bus.addr == `GSL_ADDR_CTRL) begin
               rd_data_r <= {30'h0000_0000, ctrl_r};
            end else if (bus.addr == `GSL_ADDR_STATUS) begin
               rd_data_r <= {24'h00_0000, com_active, supply_ok, state_r,
                             cur_limit_r, sel_r, warn_r, err_r};
            end else if (bus.addr == `GSL_ADDR_IRQ_STAT) begin
               rd_data_r <= {28'h000_0000, irq_stat};
            end else if (bus.addr == `GSL_ADDR_IRQ_MASK) begin
               rd_data_r <= {28'h000_0000, irq_mask};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault latch.
   // Acknowledge is both commands high together, or the software pulse.
   assign ack_req = (cmd_open && cmd_close) || sw_ack_r;
   // An acknowledge counts only once the error condition is gone.
   assign ack_ok  = ack_req && !ot_err && err_r;

   // Supply loss clears; a live error sets and beats any acknowledge.
   always_comb begin
      err_nxt = err_r;
      if (!supply_ok) begin
         err_nxt = 1'b0;
      end else if (ot_err) begin
         err_nxt = 1'b1;
      end else if (ack_ok) begin
         err_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         err_r  <= 1'b0;
         warn_r <= 1'b0;
         sel_r  <= 1'b0;
      end else if (ce) begin
         err_r  <= err_nxt;
         warn_r <= ot_warn && supply_ok;
         sel_r  <= sel_between && supply_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         GSL_OFF: begin
            if (supply_ok) begin
               state_nxt = GSL_READY;
            end
         end
         GSL_READY: begin
            if (!supply_ok) begin
               state_nxt = GSL_OFF;
            end else if (err_nxt) begin
               state_nxt = GSL_ERR;
            end else if (ot_warn) begin
               state_nxt = GSL_WARN;
            end
         end
         GSL_WARN: begin
            if (!supply_ok) begin
               state_nxt = GSL_OFF;
            end else if (err_nxt) begin
               state_nxt = GSL_ERR;
            end else if (!ot_warn) begin
               state_nxt = GSL_READY;
            end
         end
         GSL_ERR: begin
            if (!supply_ok) begin
               state_nxt = GSL_OFF;
            end else if (!err_nxt) begin
               state_nxt = ot_warn ? GSL_WARN : GSL_READY;
            end
         end
         default: begin
            state_nxt = GSL_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= GSL_OFF;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Motor side: commands gated while an error is pending.
   always_ff @(posedge clk) begin
      if (reset) begin
         drv_open_r  <= 1'b0;
         drv_close_r <= 1'b0;
         cur_limit_r <= 1'b0;
      end else if (ce) begin
         // Both high is an acknowledge, never a move.
         drv_open_r  <= cmd_open && !cmd_close && !err_nxt
                        && !ctrl_r[`GSL_CTRL_IDLE] && supply_ok;
         drv_close_r <= cmd_close && !cmd_open && !err_nxt
                        && !ctrl_r[`GSL_CTRL_IDLE] && supply_ok;
         cur_limit_r <= ot_warn && supply_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Blink sources.
   gsl_blink #(.TOGGLE_CYC(SLOW_TOGGLE_CYC)) u_slow (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .run     (err_r),
      .phase_r (slow_ph)
   );
   gsl_blink #(.TOGGLE_CYC(FAST_TOGGLE_CYC)) u_fast (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .run     (sel_r),
      .phase_r (fast_ph)
   );
   gsl_blink #(.TOGGLE_CYC(COM_TOGGLE_CYC)) u_com (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .run     (com_active),
      .phase_r (com_ph)
   );

   // Link traffic keeps the activity window open for a hold time.
   always_ff @(posedge clk) begin
      if (reset) begin
         hold_r <= 27'h000_0000;
      end else if (ce) begin
         if (link_activity && supply_ok) begin
            hold_r <= COM_HOLD_CYC;
         end else if (hold_r != 27'h000_0000) begin
            hold_r <= hold_r - 27'h000_0001;
         end
      end
   end
   assign com_active = (hold_r != 27'h000_0000);

   ////////////////////////////////////////////////////////////////////////
   // Indicators.
   assign any_fault = err_r || ext_fault;

   always_ff @(posedge clk) begin
      if (reset) begin
         led_r <= '0;
      end else if (ce) begin
         led_r.ready <= supply_ok;
         // Error blink over selector blink over steady warning.
         if (err_r) begin
            led_r.error <= slow_ph;
         end else if (sel_r) begin
            led_r.error <= fast_ph;
         end else begin
            led_r.error <= warn_r;
         end
         led_r.power    <= supply_ok && logic_v_ok && act_v_ok;
         led_r.com      <= com_active && com_ph;
         led_r.stat_grn <= supply_ok && electronics_ok && !any_fault;
         led_r.stat_red <= supply_ok && electronics_ok && any_fault;
      end
   end

   // Fault report toward the serial link.
   always_ff @(posedge clk) begin
      if (reset) begin
         err_msg_valid_r <= 1'b0;
         err_code_r      <= `GSL_CODE_NONE;
      end else if (ce) begin
         err_msg_valid_r <= supply_ok && any_fault;
         if (!supply_ok || !any_fault) begin
            err_code_r <= `GSL_CODE_NONE;
         end else if (err_r) begin
            err_code_r <= `GSL_CODE_OVERTEMP;
         end else begin
            err_code_r <= `GSL_CODE_FAULT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events and status.
   always_comb begin
      ev = 4'h0;
      ev[`GSL_EV_ERR]  = err_nxt && !err_r;
      ev[`GSL_EV_WARN] = ot_warn && supply_ok && !warn_r;
      ev[`GSL_EV_SEL]  = sel_between && supply_ok && !sel_r;
      ev[`GSL_EV_ACK]  = err_r && !err_nxt && supply_ok;
   end

   gsl_evreg u_evreg (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .ev      (ev),
      .wr_stat (wr_stat),
      .wr_mask (wr_mask),
      .wdata   (bus.wdata[3:0]),
      .stat_r  (irq_stat),
      .mask_r  (irq_mask),
      .irq_r   (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_ack;
      ce && supply_ok && err_r && !ot_err && ack_req;
   endsequence
   sequence s_quiet;
      ce && !ot_err && !sel_r && !warn_r;
   endsequence

   a_ready_supply: assert property ((ce && !reset) |=> led_r.ready == $past(supply_ok))
      else $error("ready indicator does not follow supply");
   a_error_dark: assert property ((ce && !err_r && !sel_r && !warn_r) |=> !led_r.error)
      else $error("fault indicator lit while all clear");
   a_warn_steady: assert property ((ce && warn_r && !err_r && !sel_r) |=> led_r.error)
      else $error("warning not shown steadily");
   a_cur_limit: assert property ((ce && supply_ok) |=> cur_limit_r == $past(ot_warn))
      else $error("current cap does not follow warning");
   a_slow_blink: assert property ((ce && err_r) |=> led_r.error == $past(slow_ph))
      else $error("error blink not shown");
   a_cmd_block: assert property ((ce && err_nxt) |=> !drv_open_r && !drv_close_r)
      else $error("command passed during error");
   a_err_hold: assert property ((ce && supply_ok && err_r && !ack_req) |=> err_r)
      else $error("error dropped without acknowledge");
   a_fast_blink: assert property ((ce && sel_r && !err_r) |=> led_r.error == $past(fast_ph))
      else $error("selector blink not shown");
   a_power_cycle: assert property ((ce && !supply_ok) |=> !err_r ##0 !led_r.ready)
      else $error("supply loss left error latched");
   a_ack_clear: assert property ((s_ack ##1 s_quiet) |=> !err_r ##0 !led_r.error)
      else $error("acknowledge did not clear error");
   a_power_led: assert property ((ce && !logic_v_ok) |=> !led_r.power)
      else $error("power indicator lit with bad voltage");
   a_com_dark: assert property ((ce && !com_active) |=> !led_r.com)
      else $error("link indicator lit without traffic");
   a_status_red: assert property ((ce && supply_ok && electronics_ok && err_r)
      |=> led_r.stat_red && !led_r.stat_grn && err_code_r == `GSL_CODE_OVERTEMP)
      else $error("fault not shown on status");
endmodule

// file: verif/gsl_ctrl_model.sv
// Behavioural machine controller that drives the open and close commands.
// Assumes the bench calls its tasks and feeds it the over-temperature level.
`timescale 1ns/10ps
module gsl_ctrl_model (
   // Clock and cooling state seen by the controller.
   input  wire logic clk,
   input  wire logic hot,
   // Commands to the gripper.
   output logic      cmd_open,
   output logic      cmd_close
);
   ////////////////////////////////////////////////////////////////////////////
   // Both commands start released so nothing moves before the first call.
   initial begin
      cmd_open = 1'b0;
      cmd_close = 1'b0;
   end

   // Sets a pair of command levels just after a clock edge.
   task automatic command(input logic op, input logic cl);
      @(posedge clk);
      cmd_open <= op;
      cmd_close <= cl;
   endtask

   // Waits, bounded, until cooled, then pulses both commands for one cycle.
   task automatic acknowledge(input int delay);
      int n;
      n = 0;
      while (hot !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      repeat (delay + 1) @(posedge clk);
      cmd_open <= 1'b1;
      cmd_close <= 1'b1;
      @(posedge clk);
      cmd_open <= 1'b0;
      cmd_close <= 1'b0;
   endtask
endmodule

// file: verif/gsl_core_bench.sv
// Self-checking bench of the gripper status and fault block.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/10ps
`include "gsl_defs.svh"
module gsl_core_bench
   import gsl_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1, ce = 1'b1;
   logic        supply_ok = 1'b1, logic_v_ok = 1'b1, act_v_ok = 1'b1, electronics_ok = 1'b1;
   logic        ot_warn = 1'b0, ot_err = 1'b0, sel_between = 1'b0;
   logic        ext_fault = 1'b0, link_activity = 1'b0;
   logic        cmd_open, cmd_close, drv_open_r, drv_close_r, cur_limit_r;
   logic        err_msg_valid_r, irq;
   logic [3:0]  err_code_r;
   logic [31:0] rd_data_r;
   gsl_led_type led_r;
   gsl_bus_type bus = '0;
   int          bad_count = 0, checked = 0, lit, run;

   ////////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   gsl_core #(.SLOW_TOGGLE_CYC(27'd12), .FAST_TOGGLE_CYC(27'd6),
              .COM_TOGGLE_CYC(27'd4), .COM_HOLD_CYC(27'd20)) i_gsl_core (
      .clk(clk), .reset(reset), .ce(ce), .supply_ok(supply_ok),
      .logic_v_ok(logic_v_ok), .act_v_ok(act_v_ok), .electronics_ok(electronics_ok),
      .ot_warn(ot_warn), .ot_err(ot_err), .sel_between(sel_between),
      .ext_fault(ext_fault), .link_activity(link_activity), .cmd_open(cmd_open),
      .cmd_close(cmd_close), .drv_open_r(drv_open_r), .drv_close_r(drv_close_r),
      .cur_limit_r(cur_limit_r), .led_r(led_r), .err_msg_valid_r(err_msg_valid_r),
      .err_code_r(err_code_r), .bus(bus), .rd_data_r(rd_data_r), .irq(irq));

   gsl_ctrl_model i_gsl_ctrl_model (.clk(clk), .hot(ot_err), .cmd_open(cmd_open),
      .cmd_close(cmd_close));

   ////////////////////////////////////////////////////////////////////////////
   // Compares a value and reports a mismatch at once.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Compares a count gathered by the bench.
   task automatic chk_cnt(input string name, input int exp, input int got);
      checked++;
      if (got != exp) begin
         bad_count++;
         $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
      end
   endtask

   // Lets n edges pass and settles just after the last one.
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One-cycle register write.
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // One-cycle register read; data is looked at in the following cycle only.
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(name, exp, rd_data_r);
   endtask

   // Samples one indicator for win cycles: lit count and longest equal run.
   task automatic blink(input int b, input int win, output int lit_n, output int run_n);
      int   cur;
      logic prev;
      lit_n = 0;
      run_n = 0;
      cur = 0;
      prev = 1'bx;
      repeat (win) begin
         wait_cyc(1);
         if (led_r[b] === 1'b1) lit_n++;
         cur = (led_r[b] === prev) ? cur + 1 : 1;
         prev = led_r[b];
         if (cur > run_n) run_n = cur;
      end
   endtask

   // A square wave of the given half period: half lit, runs of exactly half.
   task automatic chk_blink(input int b, input int half);
      blink(b, 4 * half, lit, run);
      chk_cnt("blink_lit", 2 * half, lit);
      chk_cnt("blink_run", half, run);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      give_verdict;
   end

   // Main test sequence.
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      wait_cyc(2);
      chk("leds_idle", 32'h0000_002A, led_r);
      reg_rd(`GSL_ADDR_IRQ_MASK, 32'h0000_0000, "mask_reset");
      reg_rd(8'h10, 32'h0000_0000, "unmapped");
      i_gsl_ctrl_model.command(1'b1, 1'b0);
      wait_cyc(2);
      chk("drv_open", 32'h0000_0002, {drv_open_r, drv_close_r});
      i_gsl_ctrl_model.command(1'b0, 1'b1);
      wait_cyc(2);
      chk("drv_close", 32'h0000_0001, {drv_open_r, drv_close_r});
      i_gsl_ctrl_model.command(1'b0, 1'b0);
      // Clock enable low freezes the command outputs.
      @(posedge clk) ce <= 1'b0;
      i_gsl_ctrl_model.command(1'b1, 1'b0);
      wait_cyc(3);
      chk("ce_freeze", 32'h0000_0000, drv_open_r);
      @(posedge clk) ce <= 1'b1;
      wait_cyc(2);
      chk("ce_run", 32'h0000_0001, drv_open_r);
      i_gsl_ctrl_model.command(1'b0, 1'b0);
      $display("test idle done");
      // Warning, then selector over warning, then both gone.
      @(posedge clk) ot_warn <= 1'b1;
      wait_cyc(3);
      chk("warn_red_limit", 32'h0000_0003, {led_r.error, cur_limit_r});
      blink(4, 12, lit, run);
      chk_cnt("warn_steady", 12, lit);
      @(posedge clk) sel_between <= 1'b1;
      wait_cyc(3);
      chk_blink(4, 6);
      @(posedge clk) sel_between <= 1'b0;
      ot_warn <= 1'b0;
      wait_cyc(3);
      chk("warn_gone", 32'h0000_0000, {led_r.error, cur_limit_r});
      $display("test warning done");
      // Latched error with interrupt, command blocking and acknowledge.
      reg_wr(`GSL_ADDR_IRQ_STAT, 32'h0000_000F);
      reg_wr(`GSL_ADDR_IRQ_MASK, 32'h0000_0001);
      @(posedge clk) ot_err <= 1'b1;
      sel_between <= 1'b1;
      wait_cyc(4);
      chk_blink(4, 12);
      chk("irq_set", 32'h0000_0001, irq);
      chk("fault_report", 32'h0000_0023, {err_msg_valid_r, err_code_r, led_r.stat_red});
      reg_rd(`GSL_ADDR_STATUS, 32'h0000_0065, "status_err");
      reg_rd(`GSL_ADDR_IRQ_STAT, 32'h0000_0005, "irq_stat");
      i_gsl_ctrl_model.command(1'b1, 1'b0);
      wait_cyc(3);
      chk("drv_blocked", 32'h0000_0000, {drv_open_r, drv_close_r});
      i_gsl_ctrl_model.command(1'b0, 1'b0);
      @(posedge clk) ot_err <= 1'b0;
      wait_cyc(4);
      chk_blink(4, 12);
      reg_wr(`GSL_ADDR_IRQ_STAT, 32'h0000_0001);
      wait_cyc(2);
      chk("irq_clear", 32'h0000_0000, irq);
      i_gsl_ctrl_model.acknowledge(5);
      wait_cyc(4);
      chk_blink(4, 6);
      reg_rd(`GSL_ADDR_IRQ_STAT, 32'h0000_000C, "irq_stat_ack");
      @(posedge clk) sel_between <= 1'b0;
      wait_cyc(3);
      chk("ack_dark", 32'h0000_0000, {led_r.error, err_code_r});
      $display("test error done");
      // Software acknowledge, then the idle bit holds commands back.
      @(posedge clk) ot_err <= 1'b1;
      @(posedge clk) ot_err <= 1'b0;
      reg_wr(`GSL_ADDR_CTRL, 32'h0000_0003);
      wait_cyc(3);
      reg_rd(`GSL_ADDR_STATUS, 32'h0000_0050, "sw_ack");
      i_gsl_ctrl_model.command(1'b1, 1'b0);
      wait_cyc(2);
      chk("drv_idle", 32'h0000_0000, drv_open_r);
      reg_rd(`GSL_ADDR_CTRL, 32'h0000_0002, "ctrl_idle");
      reg_wr(`GSL_ADDR_CTRL, 32'h0000_0000);
      wait_cyc(2);
      chk("drv_resume", 32'h0000_0001, drv_open_r);
      i_gsl_ctrl_model.command(1'b0, 1'b0);
      $display("test software done");
      // Error cleared by a supply cycle.
      @(posedge clk) ot_err <= 1'b1;
      wait_cyc(3);
      @(posedge clk) ot_err <= 1'b0;
      supply_ok <= 1'b0;
      wait_cyc(3);
      chk("supply_off", 32'h0000_0000, led_r.ready);
      @(posedge clk) supply_ok <= 1'b1;
      wait_cyc(4);
      chk("supply_cycle", 32'h0000_0000, {led_r.error, err_code_r});
      $display("test supply done");
      // Voltage, electronics and other faults on the power and status indicators and the fault code.
      @(posedge clk) act_v_ok <= 1'b0;
      electronics_ok <= 1'b0;
      wait_cyc(3);
      chk("bad_power", 32'h0000_0000, {led_r.power, led_r.stat_grn});
      @(posedge clk) act_v_ok <= 1'b1;
      logic_v_ok <= 1'b0;
      electronics_ok <= 1'b1;
      ext_fault <= 1'b1;
      wait_cyc(3);
      chk("ext_fault", 32'h0000_0012,
          {led_r.power, led_r.stat_grn, led_r.stat_red, err_code_r});
      @(posedge clk) ext_fault <= 1'b0;
      logic_v_ok <= 1'b1;
      $display("test faults done");
      // Link activity flashes the link indicator, then it goes dark.
      @(posedge clk) link_activity <= 1'b1;
      @(posedge clk) link_activity <= 1'b0;
      blink(2, 16, lit, run);
      chk_cnt("com_run", 4, run);
      wait_cyc(30);
      blink(2, 12, lit, run);
      chk_cnt("com_dark", 0, lit);
      $display("test link done");
      give_verdict;
   end
endmodule
